// ---- pbsc_pkg.sv ----
// package: constants and carrier types for the pipelined burst sram core
// ----------------------------------------------------------------------
// How it works
// - 524288 words, 36 bits, four nine-bit lanes
// - synchronous inputs except clock gate registered each enabled rising edge
// - selects checked only at load, low-high-low
// - every access starts with load/step low
// - step high advances counter, ignores read/write
// - read/write fixed at load, kept through burst
// - read with output enable high is dummy
// - write with all lanes high aborts
// - each lane enable gates its nine bits
// - lane enables go with address, applied later
// - all lane enables low writes whole word
// - clock gate high freezes all state
// - sleep ignores inputs, keeps array, floats pins
// - output enable gates drivers without clock
// - burst order high interleaved, low linear
// - load latches upper address, presets counter
// - interleaved: start pair xor burst count
// - linear: low pair increments modulo four
// - burst wraps back to loaded start
// ----------------------------------------------------------------------
package pbsc_pkg;
    localparam int ADDR_W      = 19;
    localparam int DATA_W      = 36;
    localparam int LANES       = 4;
    localparam int LANE_W      = 9;
    localparam int DEPTH       = 524288;
    localparam int PIPE_STAGES = 2;

    typedef enum logic [3:0] {
        PBSC_DESEL = 4'b0001,
        PBSC_READ  = 4'b0010,
        PBSC_WRITE = 4'b0100,
        PBSC_DUMMY = 4'b1000
    } pbsc_cyc_type;

    typedef struct packed {
        logic                 valid;
        logic                 is_read;
        logic [ADDR_W-1:0]    addr;
        logic [LANES-1:0]     lane_we_n;
    } pbsc_stage_type;

    typedef struct packed {
        logic                 sel_low_first_n;
        logic                 sel_high_second;
        logic                 sel_low_third_n;
        logic                 load_or_step;
        logic                 read_not_write;
        logic [LANES-1:0]     lane_we_n;
        logic [ADDR_W-1:0]    word_address;
    } pbsc_ctrl_type;

    localparam pbsc_stage_type STAGE_RST = '0;
endpackage

// ---- pbsc_array.sv ----
// file: word array with per-lane write and registered read data
`timescale 1ns/1ps
`default_nettype none
module pbsc_array
    import pbsc_pkg::*;
(
    // clock
    input  wire logic                 sys_clk,
    // access
    input  wire logic                 rd_en,
    input  wire logic                 wr_en,
    input  wire logic [ADDR_W-1:0]    addr,
    input  wire logic [LANES-1:0]     lane_we_n,
    input  wire logic [DATA_W-1:0]    wr_data,
    output logic      [DATA_W-1:0]    rd_data_r
);
    logic [DATA_W-1:0] mem [DEPTH];

    // array has no reset: contents only change by writes
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_en && !lane_we_n[i]) begin
                mem[addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end
        end
        if (rd_en) begin
            rd_data_r <= mem[addr];
        end
    end
endmodule
`default_nettype wire

// ---- pbsc_core.sv ----
// file: control pipeline of the pipelined burst sram core
`timescale 1ns/1ps
`default_nettype none
module pbsc_core
    import pbsc_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    // synchronous control
    input  wire logic                 select_low_first_n,
    input  wire logic                 select_high_second,
    input  wire logic                 select_low_third_n,
    input  wire logic                 load_or_step,
    input  wire logic                 read_write_n,
    input  wire logic                 clock_gate_n,
    input  wire logic [LANES-1:0]     lane_write_en_n,
    input  wire logic [ADDR_W-1:0]    word_address,
    // asynchronous and static control
    input  wire logic                 output_en_n,
    input  wire logic                 sleep_request,
    input  wire logic                 burst_order_sel,
    // data pins
    input  wire logic [DATA_W-1:0]    data_in,
    output logic      [DATA_W-1:0]    data_out,
    output logic      [DATA_W-1:0]    data_oe_n
);
    // ------------------------------------------------------------------
    // input capture
    // ------------------------------------------------------------------
    pbsc_ctrl_type ctrl_r, ctrl_nxt;
    logic          run;
    logic          cap_v_r, cap_v_nxt;

    // stall or sleep freezes every state register
    assign run = !clock_gate_n ? 1'b1 : 1'b0;
    wire logic act = run && !sleep_request;

    always_comb begin
        ctrl_nxt  = ctrl_r;
        cap_v_nxt = cap_v_r;
        if (act) begin
            ctrl_nxt.sel_low_first_n = select_low_first_n;
            ctrl_nxt.sel_high_second = select_high_second;
            ctrl_nxt.sel_low_third_n = select_low_third_n;
            ctrl_nxt.load_or_step    = load_or_step;
            ctrl_nxt.read_not_write  = read_write_n;
            ctrl_nxt.lane_we_n       = lane_write_en_n;
            ctrl_nxt.word_address    = word_address;
            cap_v_nxt                = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r  <= '0;
            cap_v_r <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            cap_v_r <= cap_v_nxt;
        end
    end

    // ------------------------------------------------------------------
    // burst state
    // ------------------------------------------------------------------
    function automatic logic [1:0] burst_low(input logic [1:0] start,
                                             input logic [1:0] cnt,
                                             input logic       ilv);
        burst_low = ilv ? (start ^ cnt) : 2'(start + cnt);
    endfunction

    pbsc_cyc_type      cyc_r, cyc_nxt;
    logic [ADDR_W-3:0] upper_r, upper_nxt;
    logic [1:0]        start_r, start_nxt;
    logic [1:0]        cnt_r, cnt_nxt;
    logic [LANES-1:0]  lanes_cur;
    logic              selected;
    logic              is_load;

    assign is_load  = cap_v_r && !ctrl_r.load_or_step;
    assign selected = !ctrl_r.sel_low_first_n && ctrl_r.sel_high_second
                      && !ctrl_r.sel_low_third_n;

    always_comb begin
        cyc_nxt   = cyc_r;
        upper_nxt = upper_r;
        start_nxt = start_r;
        cnt_nxt   = cnt_r;
        if (act && cap_v_r) begin
            if (is_load) begin
                upper_nxt = ctrl_r.word_address[ADDR_W-1:2];
                start_nxt = ctrl_r.word_address[1:0];
                cnt_nxt   = 2'b00;
                if (!selected) begin
                    cyc_nxt = PBSC_DESEL;
                end else if (ctrl_r.read_not_write) begin
                    cyc_nxt = PBSC_READ;
                end else begin
                    cyc_nxt = PBSC_WRITE;
                end
            end else begin
                // two-bit count wraps to the loaded start
                cnt_nxt = 2'(cnt_r + 2'b01);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_r   <= PBSC_DESEL;
            upper_r <= '0;
            start_r <= 2'b00;
            cnt_r   <= 2'b00;
        end else begin
            cyc_r   <= cyc_nxt;
            upper_r <= upper_nxt;
            start_r <= start_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // access pipeline, four enabled edges from address capture to data
    // ------------------------------------------------------------------
    // decode uses the cycle just captured so loads issue without a bubble
    pbsc_stage_type issue, st1_r, st1_nxt, st2_r, st2_nxt;
    logic [1:0]     low_now;

    always_comb begin
        issue    = STAGE_RST;
        low_now  = burst_low(start_r, cnt_nxt, burst_order_sel);
        lanes_cur = ctrl_r.lane_we_n;
        if (cap_v_r) begin
            if (is_load && selected) begin
                issue.valid   = 1'b1;
                issue.is_read = ctrl_r.read_not_write;
                issue.addr    = ctrl_r.word_address;
            end else if (!is_load && (cyc_r != PBSC_DESEL)) begin
                issue.valid   = 1'b1;
                issue.is_read = (cyc_r != PBSC_WRITE);
                issue.addr    = {upper_r, low_now};
            end
            issue.lane_we_n = lanes_cur;
        end
        st1_nxt = st1_r;
        st2_nxt = st2_r;
        if (act) begin
            st1_nxt = issue;
            st2_nxt = st1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st1_r <= STAGE_RST;
            st2_r <= STAGE_RST;
        end else begin
            st1_r <= st1_nxt;
            st2_r <= st2_nxt;
        end
    end

    // ------------------------------------------------------------------
    // array and data pins
    // ------------------------------------------------------------------
    logic              wr_go;
    logic              rd_go;
    logic [DATA_W-1:0] rd_data;
    logic              rd_vis_r, rd_vis_nxt;

    // abort when no lane enabled: nothing written, pins float
    assign wr_go = act && st2_r.valid && !st2_r.is_read
                   && (st2_r.lane_we_n != 4'hF);
    // reads and writes both leave from the last stage: one array port, no clash
    assign rd_go = act && st2_r.valid && st2_r.is_read;

    pbsc_array u_array (
        .sys_clk   (sys_clk),
        .rd_en     (rd_go),
        .wr_en     (wr_go),
        .addr      (st2_r.addr),
        .lane_we_n (st2_r.lane_we_n),
        .wr_data   (data_in),
        .rd_data_r (rd_data)
    );

    always_comb begin
        rd_vis_nxt = rd_vis_r;
        if (act) begin
            rd_vis_nxt = st2_r.valid && st2_r.is_read;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_vis_r <= 1'b0;
        end else begin
            rd_vis_r <= rd_vis_nxt;
        end
    end

    // dummy read: sequence runs, only the drivers stay off
    assign data_out  = rd_data;
    assign data_oe_n = {DATA_W{!(rd_vis_r && !output_en_n && !sleep_request)}};

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence load_sel_read;
        act && cap_v_r && is_load && selected && ctrl_r.read_not_write;
    endsequence

    sleep_floats_a: assert property (sleep_request |-> &data_oe_n)
        else $error("pins driven during sleep");
    oe_gates_a: assert property (output_en_n |-> &data_oe_n)
        else $error("pins driven with output enable high");
    stall_hold_a: assert property (!act |=> $stable(cnt_r) && $stable(cyc_r))
        else $error("state moved on a stalled edge");
    load_read_a: assert property (load_sel_read |=> cyc_r == PBSC_READ)
        else $error("selected read load not taken");
    desel_load_a: assert property (act && is_load && !selected |=> cyc_r == PBSC_DESEL)
        else $error("unselected load did not deselect");
    step_count_a: assert property (act && cap_v_r && !is_load
                                   |=> cnt_r == 2'($past(cnt_r) + 2'b01))
        else $error("burst counter did not advance");
    desel_stay_a: assert property (act && cap_v_r && !is_load && cyc_r == PBSC_DESEL
                                   |=> !st1_r.valid)
        else $error("access issued while deselected");
    pipe_two_a: assert property (load_sel_read ##1 act [*2] |=> rd_vis_r)
        else $error("read data not presented two edges later");
    abort_none_a: assert property (st2_r.lane_we_n == 4'hF |-> !wr_go)
        else $error("write with all lanes disabled");
endmodule
`default_nettype wire

// ---- pbsc_ctrl_model.sv ----
// memory controller model: write data timing on the data bus
`timescale 1ns/1ps
`default_nettype none
module pbsc_ctrl_model
    import pbsc_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // commands as put on the device pins
    input  wire pbsc_ctrl_type     cmd,
    input  wire logic              run,
    input  wire logic [DATA_W-1:0] wdata,
    // data bus toward the device
    output logic      [DATA_W-1:0] data_in
);
    logic [2:0]        wr_q = 3'b000;
    logic [DATA_W-1:0] d_q [3];
    logic              sel = 1'b0;
    logic              rd = 1'b1;
    initial begin
        data_in = '0;
    end
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_q = 3'b000;
            sel = 1'b0;
        end else if (run) begin
            // a new burst only ever starts with load_or_step low
            if (!cmd.load_or_step) begin
                sel = !cmd.sel_low_first_n && cmd.sel_high_second && !cmd.sel_low_third_n;
                rd = cmd.read_not_write;
            end
            // lane enables travel with the address, data follows later
            wr_q = {wr_q[1:0], sel && !rd && cmd.lane_we_n != 4'hf};
            d_q[2] = d_q[1];
            d_q[1] = d_q[0];
            d_q[0] = wdata;
            // released bus inverts on each run edge, so every second one shows the older copy again
            #1 data_in = wr_q[2] ? d_q[2] : ~data_in;
        end
    end
endmodule
`default_nettype wire

// ---- tb_pipelined_burst_sram_core.sv ----
// testbench: random traffic against a queue model of the burst sram
`timescale 1ns/1ps
`default_nettype none
module tb_pipelined_burst_sram_core
    import pbsc_pkg::*;
();
    // --------
    // wiring
    // --------
    logic              sys_clk = 1'b0;
    logic              reset_n;
    logic              clock_gate_n;
    logic              output_en_n;
    logic              sleep_request;
    logic              burst_order_sel;
    pbsc_ctrl_type     cmd;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] data_in;
    logic [DATA_W-1:0] data_out;
    logic [DATA_W-1:0] data_oe_n;
    wire logic         run_en = reset_n && !clock_gate_n && !sleep_request;
    pbsc_core u_pbsc_core (.sys_clk, .reset_n,
        .select_low_first_n(cmd.sel_low_first_n), .select_high_second(cmd.sel_high_second),
        .select_low_third_n(cmd.sel_low_third_n), .load_or_step(cmd.load_or_step),
        .read_write_n(cmd.read_not_write), .clock_gate_n, .lane_write_en_n(cmd.lane_we_n),
        .word_address(cmd.word_address), .output_en_n, .sleep_request, .burst_order_sel,
        .data_in, .data_out, .data_oe_n);
    pbsc_ctrl_model u_pbsc_ctrl_model (.sys_clk, .reset_n, .cmd, .run(run_en), .wdata,
        .data_in);
    // --------
    // model
    // --------
    logic [DATA_W-1:0] mem [int];
    logic [24:0]       pq [$];
    logic [24:0]       res;
    logic [DATA_W-1:0] res_data;
    logic              m_sel;
    logic              m_rd;
    logic [ADDR_W-1:0] m_addr;
    logic [1:0]        m_cnt;
    logic [31:0]       rnd = 32'h0000_8764;
    int                n_errors = 0;
    int                cmp_count = 0;
    int                cyc = 0;
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
    endfunction
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check_drive(logic [DATA_W-1:0] exp);
        cmp_count++;
        if (data_oe_n !== exp) begin
            n_errors++;
            $display("CHECK FAILED data_oe_n exp %h got %h", exp, data_oe_n);
        end
    endtask
    task automatic check_data(logic [DATA_W-1:0] exp);
        cmp_count++;
        if (data_out !== exp) begin
            n_errors++;
            $display("CHECK FAILED data_out exp %h got %h", exp, data_out);
        end
    endtask
    task automatic model_edge();
        logic [ADDR_W-1:0] a;
        if (!cmd.load_or_step) begin
            m_sel = !cmd.sel_low_first_n && cmd.sel_high_second && !cmd.sel_low_third_n;
            m_rd = cmd.read_not_write;
            m_addr = cmd.word_address;
            m_cnt = 2'd0;
        end else begin
            m_cnt = m_cnt + 2'd1;
        end
        a = {m_addr[18:2], burst_order_sel ? m_addr[1:0] ^ m_cnt : m_addr[1:0] + m_cnt};
        pq.push_back({m_sel ? (m_rd ? 2'd1 : 2'd2) : 2'd0, cmd.lane_we_n, a});
        if (pq.size() > 3) begin
            res = pq.pop_front();
            a = res[18:0];
            if (res[24:23] != 2'd0) begin
                if (!mem.exists(a)) begin
                    mem[a] = 'x;
                end
                for (int i = 0; i < LANES; i++) begin
                    if (res[24:23] == 2'd2 && !res[19+i]) begin
                        mem[a][LANE_W*i+:LANE_W] = data_in[LANE_W*i+:LANE_W];
                    end
                end
                res_data = mem[a];
            end
        end
    endtask
    // --------
    // stimulus
    // --------
    task automatic drive_random();
        logic [31:0] r;
        repeat (8) rnd = lfsr_next(rnd);
        r = rnd;
        cmd.load_or_step = r[0];
        cmd.read_not_write = r[1];
        cmd.sel_low_first_n = r[5:2] == 4'h0;
        cmd.sel_high_second = r[5:2] != 4'h1;
        cmd.sel_low_third_n = r[5:2] == 4'h2;
        cmd.lane_we_n = r[6] ? 4'h0 : r[10:7];
        cmd.word_address = {r[11], 14'h0000, r[15:12]};
        clock_gate_n = r[18:16] == 3'd0;
        sleep_request = r[23:19] == 5'd0;
        output_en_n = r[26:24] == 3'd0;
        wdata = {r[3:0], lfsr_next(r)};
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        cmd = '1;
        wdata = '0;
        clock_gate_n = 1'b0;
        output_en_n = 1'b0;
        sleep_request = 1'b0;
        for (int ph = 0; ph < 2; ph++) begin
            reset_n = 1'b0;
            burst_order_sel = ph == 0;
            m_sel = 1'b0;
            m_cnt = 2'd0;
            m_addr = '0;
            res = '0;
            pq.delete();
            repeat (ph ? 2 : 20) @(posedge sys_clk);
            #1;
            check_drive('1);
            reset_n = 1'b1;
            repeat (1500) begin
                @(posedge sys_clk);
                // stalled or sleeping edges leave the model untouched
                if (run_en) begin
                    model_edge();
                end
                #1;
                check_drive({DATA_W{!(!sleep_request && res[24:23] == 2'd1 && !output_en_n)}});
                if (!sleep_request && res[24:23] == 2'd1 && !output_en_n && !$isunknown(res_data)) begin
                    check_data(res_data);
                end
                drive_random();
            end
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
